// file: hw/uat_core.sv
// uart transmit and receive datapath with fifos, line status and auto flow control
// Function
// - transmit one bit per 16, 8 or 4 oversampling ticks by mode
// - frame is start, data bits, optional parity, then stop bits
// - data goes out least significant bit first
// - with fifo enabled, holding writes push into a 64-byte transmit fifo
// - without fifo, holding-empty sets on transfer, shifter-empty when holding and shifter both empty
// - transmit-empty interrupt needs interrupt enable bit 1
// - with fifo, holding-empty tracks empty fifo; interrupt below transmit trigger
// - with fifo, shifter-empty needs both fifo and shifter empty
// - start edge validated by sample after 8, 4 or 2 ticks
// - data, parity and stop bits sampled at bit centre
// - receive fifo holds 64 entries of data plus three error tags
// - reading receive holding pops fifo and shows new head tags at once
// - receive-ready per character or at trigger, gated by enable bit 0
// - timeout after four character lengths plus twelve bit times idle
// - auto request-to-send enabled by feature bit 6, started by modem bit 1
// - request-to-send rising edge sets flow status when enable bit 6
// - request-to-send goes high at halt level, low again at resume level
// - receiver keeps storing characters while request-to-send is high
// - auto clear-to-send holds transmit between characters while input high
// - clear-to-send rising edge sets flow status when enable bit 7
// - sampling mode field selects 16x, 8x or 4x
// - line control bits 1:0 select five to eight data bits
`timescale 1ns/100ps
`include "uat_defines.svh"

module uat_core (
	input  wire logic                  core_clk, // 200 MHz core clock
	input  wire logic                  rst_n,    // async reset, active low
	input  wire uat_pkg::uat_axi_req_t axi_req,  // axi4-lite request channels
	output uat_pkg::uat_axi_rsp_t      axi_rsp,  // axi4-lite response channels
	input  wire logic                  os_tick,  // one-cycle oversampling enable
	input  wire logic                  rxd,      // serial receive input
	output logic                       txd,      // serial transmit output
	input  wire logic                  cts_n,    // clear-to-send, active low
	output logic                       rts_n     // request-to-send, active low
);
	import uat_pkg::*;

	uat_state_t  s_q;
	uat_state_t  s_d;
	logic [7:0]  tx_head;
	logic [10:0] rx_head;
	logic        tx_we;
	logic        rx_we;
	logic [10:0] rx_wdata;
	logic        tx_push;
	logic        tx_pop;
	logic        rx_push;
	logic        rx_pop;
	logic [4:0]  bit_len;
	logic [3:0]  dlen;
	logic [6:0]  cap;
	logic [6:0]  tmo_limit;
	logic [7:0]  dmask;
	logic [7:0]  lstat;
	logic [7:0]  istat;
	logic [5:0]  is_code;
	logic        tx_adv;
	logic        rx_adv;
	logic        rx_half;
	logic        bit_tick;
	logic [7:0]  rx_data;
	logic        aw_take;
	logic        w_take;
	logic        ar_take;

	// oversampling ticks per bit from the sampling mode field
	function automatic logic [4:0] os_per_bit(input logic [1:0] mode);
		unique case (mode)
			2'b01:   os_per_bit = `UAT_OS_8X;
			2'b10:   os_per_bit = `UAT_OS_4X;
			default: os_per_bit = `UAT_OS_16X; // 11 is reserved, treated as 16x
		endcase
	endfunction : os_per_bit

	// fifo fill level selected by a two-bit trigger field
	function automatic logic [6:0] trig_level(input logic [1:0] sel);
		unique case (sel)
			2'b00: trig_level = `UAT_TRIG_0;
			2'b01: trig_level = `UAT_TRIG_1;
			2'b10: trig_level = `UAT_TRIG_2;
			2'b11: trig_level = `UAT_TRIG_3;
		endcase
	endfunction : trig_level

	// fifo storage; read address follows the next pointer so the head is ready a cycle later
	uat_mem #(.WIDTH(8)) u_tx_mem (
		.core_clk (core_clk),
		.we       (tx_we),
		.waddr    (s_q.tx_wr),
		.wdata    (s_q.w_data),
		.raddr    (s_d.tx_rd),
		.rdata    (tx_head)
	);

	uat_mem #(.WIDTH(11)) u_rx_mem (
		.core_clk (core_clk),
		.we       (rx_we),
		.waddr    (s_q.rx_wr),
		.wdata    (rx_wdata),
		.raddr    (s_d.rx_rd),
		.rdata    (rx_head)
	);

	// frame geometry from the line and divisor-fraction registers
	always_comb begin
		bit_len   = os_per_bit(s_q.dfrac[5:4]);
		dlen      = 4'(5 + s_q.lctl[1:0]);
		dmask     = 8'(8'hFF >> (4'h8 - dlen));
		cap       = s_q.fifo_en ? `UAT_FIFO_DEPTH : 7'h01;
		tmo_limit = 7'(((1 + dlen + s_q.lctl[`UAT_LC_PAREN] + s_q.lctl[`UAT_LC_STOP2] + 1) << `UAT_TMO_CHARS)
			+ `UAT_TMO_EXTRA);
		tx_adv    = os_tick && (s_q.tx_os == bit_len - 5'h01);
		rx_adv    = os_tick && (s_q.rx_os == bit_len - 5'h01);
		rx_half   = os_tick && (s_q.rx_os == (bit_len >> 1) - 5'h01);
		bit_tick  = os_tick && (s_q.bt_os == bit_len - 5'h01);
		rx_data   = 8'(s_q.rx_shifter >> (4'h8 - dlen));
	end

	// line status and priority-coded interrupt status
	always_comb begin
		lstat    = 8'h00;
		lstat[0] = (s_q.rx_cnt != 7'h00);
		lstat[1] = s_q.overrun;
		lstat[4:2] = (s_q.rx_cnt != 7'h00) ? rx_head[10:8] : 3'b000;
		lstat[5] = (s_q.tx_cnt == 7'h00);
		lstat[6] = (s_q.tx_cnt == 7'h00) && (s_q.tx_st == TX_IDLE);
		if (s_q.ien[`UAT_IEN_RXRDY] && s_q.rx_tmo) begin
			is_code = `UAT_IS_RXTMO;
		end else if (s_q.ien[`UAT_IEN_RXRDY] && (s_q.fifo_en ? (s_q.rx_cnt >= trig_level(s_q.rx_trig))
				: (s_q.rx_cnt != 7'h00))) begin
			is_code = `UAT_IS_RXRDY;
		end else if (s_q.ien[`UAT_IEN_TXEMPTY] && (s_q.fifo_en ? (s_q.tx_cnt < trig_level(s_q.tx_trig))
				: (s_q.tx_cnt == 7'h00))) begin
			is_code = `UAT_IS_TXEMPTY;
		end else if (s_q.flow_evt) begin
			is_code = `UAT_IS_FLOW;
		end else begin
			is_code = `UAT_IS_NONE;
		end
		istat = {{2{s_q.fifo_en}}, is_code};
	end

	// next-state logic for bus, fifos, transmitter, receiver and flow control
	always_comb begin
		s_d      = s_q;
		tx_we    = 1'b0;
		rx_we    = 1'b0;
		rx_wdata = 11'h000;
		tx_push  = 1'b0;
		tx_pop   = 1'b0;
		rx_push  = 1'b0;
		rx_pop   = 1'b0;
		aw_take  = axi_req.awvalid && !s_q.aw_hold && !s_q.bvalid;
		w_take   = axi_req.wvalid && !s_q.w_hold && !s_q.bvalid;
		ar_take  = axi_req.arvalid && !s_q.rvalid;

		// write channels are captured independently, then committed together
		if (aw_take) begin
			s_d.aw_hold = 1'b1;
			s_d.aw_addr = axi_req.awaddr;
		end
		if (w_take) begin
			s_d.w_hold  = 1'b1;
			s_d.w_data  = axi_req.wdata[7:0];
			s_d.w_lane0 = axi_req.wstrb[0];
		end
		if (s_q.bvalid && axi_req.bready) begin
			s_d.bvalid = 1'b0;
		end
		if (s_q.aw_hold && s_q.w_hold) begin
			s_d.aw_hold = 1'b0;
			s_d.w_hold  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = `UAT_RESP_OKAY;
			if (s_q.w_lane0) begin
				unique case (s_q.aw_addr)
					`UAT_OFS_HOLD: begin
						if (s_q.tx_cnt < cap) begin
							tx_we   = 1'b1;
							tx_push = 1'b1;
						end
					end
					// upper enables stay locked until the enhanced bit is set
					`UAT_OFS_IEN:   s_d.ien = s_q.efeat[`UAT_EF_ENH] ? s_q.w_data
						: {s_q.ien[7:4], s_q.w_data[3:0]};
					`UAT_OFS_ISTAT: begin
						s_d.fifo_en = s_q.w_data[`UAT_FC_EN];
						s_d.tx_trig = s_q.w_data[5:4];
						s_d.rx_trig = s_q.w_data[7:6];
					end
					`UAT_OFS_LCTL:  s_d.lctl  = s_q.w_data;
					`UAT_OFS_MCTL:  s_d.mctl  = s_q.w_data;
					`UAT_OFS_EFEAT: s_d.efeat = s_q.w_data;
					`UAT_OFS_FTHR:  s_d.fthr  = s_q.w_data;
					`UAT_OFS_DFRAC: s_d.dfrac = s_q.w_data;
					default:        s_d.bresp = `UAT_RESP_SLVERR;
				endcase
			end
		end

		// reads answer one cycle after the address is taken; some reads have side effects
		if (s_q.rvalid && axi_req.rready) begin
			s_d.rvalid = 1'b0;
		end
		if (ar_take) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = `UAT_RESP_OKAY;
			unique case (axi_req.araddr)
				`UAT_OFS_HOLD: begin
					s_d.rdata = rx_head[7:0];
					rx_pop    = (s_q.rx_cnt != 7'h00);
				end
				`UAT_OFS_IEN:   s_d.rdata = s_q.ien;
				`UAT_OFS_ISTAT: begin
					s_d.rdata    = istat;
					s_d.flow_evt = 1'b0;
				end
				`UAT_OFS_LCTL:  s_d.rdata = s_q.lctl;
				`UAT_OFS_MCTL:  s_d.rdata = s_q.mctl;
				`UAT_OFS_LSTAT: begin
					s_d.rdata   = lstat;
					s_d.overrun = 1'b0;
				end
				`UAT_OFS_EFEAT: s_d.rdata = s_q.efeat;
				`UAT_OFS_FTHR:  s_d.rdata = s_q.fthr;
				`UAT_OFS_DFRAC: s_d.rdata = s_q.dfrac;
				default: begin
					s_d.rdata = 8'h00;
					s_d.rresp = `UAT_RESP_SLVERR;
				end
			endcase
		end

		// transmitter; clear-to-send is only checked between characters
		s_d.tx_os = tx_adv ? 5'h00 : (os_tick ? s_q.tx_os + 5'h01 : s_q.tx_os);
		unique case (s_q.tx_st)
			TX_IDLE: begin
				s_d.txd   = 1'b1;
				s_d.tx_os = 5'h00;
				if ((s_q.tx_cnt != 7'h00) && !(s_q.efeat[`UAT_EF_ACTS] && cts_n)) begin
					tx_pop         = 1'b1;
					s_d.tx_shifter = tx_head & dmask;
					s_d.tx_par     = ^(tx_head & dmask) ^ ~s_q.lctl[`UAT_LC_EVEN];
					s_d.txd        = 1'b0;
					s_d.tx_st      = TX_START;
				end
			end
			TX_START: begin
				if (tx_adv) begin
					s_d.txd        = s_q.tx_shifter[0];
					s_d.tx_shifter = s_q.tx_shifter >> 1;
					s_d.tx_bit     = 3'h0;
					s_d.tx_st      = TX_DATA;
				end
			end
			TX_DATA: begin
				if (tx_adv) begin
					if (s_q.tx_bit == 3'(dlen - 4'h1)) begin
						s_d.txd    = s_q.lctl[`UAT_LC_PAREN] ? s_q.tx_par : 1'b1;
						s_d.tx_st  = s_q.lctl[`UAT_LC_PAREN] ? TX_PAR : TX_STOP;
						s_d.tx_bit = 3'h0;
					end else begin
						s_d.txd        = s_q.tx_shifter[0];
						s_d.tx_shifter = s_q.tx_shifter >> 1;
						s_d.tx_bit     = s_q.tx_bit + 3'h1;
					end
				end
			end
			TX_PAR: begin
				if (tx_adv) begin
					s_d.txd    = 1'b1;
					s_d.tx_bit = 3'h0;
					s_d.tx_st  = TX_STOP;
				end
			end
			TX_STOP: begin
				if (tx_adv) begin
					if (s_q.tx_bit == {2'b00, s_q.lctl[`UAT_LC_STOP2]}) begin
						s_d.tx_st = TX_IDLE;
					end else begin
						s_d.tx_bit = s_q.tx_bit + 3'h1;
					end
				end
			end
			default: s_d.tx_st = TX_IDLE;
		endcase

		// receiver; keeps storing even while request-to-send is high
		s_d.rxd_prev = rxd;
		s_d.rx_os    = (rx_adv || rx_half && s_q.rx_st == RX_START) ? 5'h00
			: (os_tick ? s_q.rx_os + 5'h01 : s_q.rx_os);
		unique case (s_q.rx_st)
			RX_IDLE: begin
				s_d.rx_os = 5'h00;
				if (s_q.rxd_prev && !rxd) begin
					s_d.rx_st = RX_START;
				end
			end
			RX_START: begin
				if (rx_half) begin
					s_d.rx_st   = rxd ? RX_IDLE : RX_DATA;
					s_d.rx_bit  = 3'h0;
					s_d.rx_perr = 1'b0;
					s_d.rx_pbit = 1'b0;
				end
			end
			RX_DATA: begin
				if (rx_adv) begin
					s_d.rx_shifter = {rxd, s_q.rx_shifter[7:1]};
					s_d.rx_bit     = s_q.rx_bit + 3'h1;
					if (s_q.rx_bit == 3'(dlen - 4'h1)) begin
						s_d.rx_st = s_q.lctl[`UAT_LC_PAREN] ? RX_PAR : RX_STOP;
					end
				end
			end
			RX_PAR: begin
				if (rx_adv) begin
					s_d.rx_pbit = rxd;
					s_d.rx_perr = rxd ^ ^rx_data ^ ~s_q.lctl[`UAT_LC_EVEN];
					s_d.rx_st   = RX_STOP;
				end
			end
			RX_STOP: begin
				if (rx_adv) begin
					s_d.rx_st = RX_IDLE;
					rx_wdata  = {!rxd && (rx_data == 8'h00) && !s_q.rx_pbit, !rxd, s_q.rx_perr, rx_data};
					if (s_q.rx_cnt < cap || rx_pop) begin
						rx_we   = 1'b1;
						rx_push = 1'b1;
					end else begin
						s_d.overrun = 1'b1;                                       // set wins over read clear
					end
				end
			end
			default: s_d.rx_st = RX_IDLE;
		endcase

		// fifo pointers and fill levels; a reset bit in the control write drops the contents
		s_d.tx_wr  = s_q.tx_wr + 6'(tx_push);
		s_d.tx_rd  = s_q.tx_rd + 6'(tx_pop);
		s_d.tx_cnt = s_q.tx_cnt + 7'(tx_push) - 7'(tx_pop);
		s_d.rx_wr  = s_q.rx_wr + 6'(rx_push);
		s_d.rx_rd  = s_q.rx_rd + 6'(rx_pop);
		s_d.rx_cnt = s_q.rx_cnt + 7'(rx_push) - 7'(rx_pop);
		if (s_q.aw_hold && s_q.w_hold && s_q.w_lane0 && s_q.aw_addr == `UAT_OFS_ISTAT) begin
			if (s_q.w_data[`UAT_FC_TXRST]) begin
				s_d.tx_wr  = 6'h00;
				s_d.tx_rd  = 6'h00;
				s_d.tx_cnt = 7'h00;
			end
			if (s_q.w_data[`UAT_FC_RXRST]) begin
				s_d.rx_wr  = 6'h00;
				s_d.rx_rd  = 6'h00;
				s_d.rx_cnt = 7'h00;
			end
		end

		// free bit-time divider and receive timeout counter
		s_d.bt_os = bit_tick ? 5'h00 : (os_tick ? s_q.bt_os + 5'h01 : s_q.bt_os);
		if (rx_push || rx_pop || s_q.rx_cnt == 7'h00) begin
			s_d.tmo    = 7'h00;
			s_d.rx_tmo = 1'b0;
		end else if (bit_tick && s_q.tmo != tmo_limit) begin
			s_d.tmo = s_q.tmo + 7'h01;
		end
		// a fresh character restarts the wait, so it must not re-arm the flag in the same cycle
		if (s_q.tmo == tmo_limit && s_q.rx_cnt != 7'h00 && !rx_pop && !rx_push) begin
			s_d.rx_tmo = 1'b1;
		end

		// auto request-to-send: halt and resume levels are in steps of four entries
		if (s_q.rx_cnt >= 7'({s_q.fthr[3:0], 2'b00}) && s_q.fthr[3:0] != 4'h0) begin
			s_d.halt = 1'b1;
		end else if (s_q.rx_cnt <= 7'({s_q.fthr[7:4], 2'b00})) begin
			s_d.halt = 1'b0;
		end
		s_d.rts_n    = !s_q.mctl[`UAT_MC_RTS] || (s_q.efeat[`UAT_EF_ARTS] && s_q.halt);
		s_d.cts_prev = cts_n;
		if ((s_q.ien[`UAT_IEN_RTS] && s_d.rts_n && !s_q.rts_n)
			|| (s_q.ien[`UAT_IEN_CTS] && cts_n && !s_q.cts_prev)) begin
			s_d.flow_evt = 1'b1;                                              // set wins over read clear
		end
	end

	// state register; only constants under reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q          <= '0;
			s_q.lctl     <= `UAT_RST_BYTE;
			s_q.fthr     <= `UAT_RST_FTHR;
			s_q.tx_st    <= TX_IDLE;
			s_q.rx_st    <= RX_IDLE;
			s_q.txd      <= 1'b1;
			s_q.rxd_prev <= 1'b1;
			s_q.rts_n    <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs; readies are combinational, data come from the state register
	always_comb begin
		axi_rsp.awready = !s_q.aw_hold && !s_q.bvalid;
		axi_rsp.wready  = !s_q.w_hold && !s_q.bvalid;
		axi_rsp.bvalid  = s_q.bvalid;
		axi_rsp.bresp   = s_q.bresp;
		axi_rsp.arready = !s_q.rvalid;
		axi_rsp.rvalid  = s_q.rvalid;
		axi_rsp.rdata   = {24'h00_0000, s_q.rdata};
		axi_rsp.rresp   = s_q.rresp;
		txd             = s_q.txd;
		rts_n           = s_q.rts_n;
	end

endmodule : uat_core

// file: hw/uat_defines.svh
// register offsets, field positions, reset values and counts for the uart datapath
`ifndef UAT_DEFINES_SVH
`define UAT_DEFINES_SVH

// byte addresses of the register words
`define UAT_OFS_HOLD      8'h00
`define UAT_OFS_IEN       8'h04
`define UAT_OFS_ISTAT     8'h08
`define UAT_OFS_LCTL      8'h0C
`define UAT_OFS_MCTL      8'h10
`define UAT_OFS_LSTAT     8'h14
`define UAT_OFS_EFEAT     8'h18
`define UAT_OFS_FTHR      8'h1C
`define UAT_OFS_DFRAC     8'h20

// reset values
`define UAT_RST_BYTE      8'h00
`define UAT_RST_FTHR      8'h00

// axi responses
`define UAT_RESP_OKAY     2'h0
`define UAT_RESP_SLVERR   2'h2

// interrupt enable bits
`define UAT_IEN_RXRDY     0
`define UAT_IEN_TXEMPTY   1
`define UAT_IEN_RTS       6
`define UAT_IEN_CTS       7

// enhanced feature bits
`define UAT_EF_ENH        4
`define UAT_EF_ARTS       6
`define UAT_EF_ACTS       7

// fifo control bits
`define UAT_FC_EN         0
`define UAT_FC_RXRST      1
`define UAT_FC_TXRST      2

// line control bits
`define UAT_LC_STOP2      2
`define UAT_LC_PAREN      3
`define UAT_LC_EVEN       4

// modem control bit that asserts request-to-send
`define UAT_MC_RTS        1

// interrupt status codes, low six bits
`define UAT_IS_NONE       6'h01
`define UAT_IS_RXTMO      6'h0C
`define UAT_IS_RXRDY      6'h04
`define UAT_IS_TXEMPTY    6'h02
`define UAT_IS_FLOW       6'h20

// fifo geometry and counts
`define UAT_FIFO_DEPTH    7'h40
`define UAT_OS_16X        5'h10
`define UAT_OS_8X         5'h08
`define UAT_OS_4X         5'h04
`define UAT_TRIG_0        7'h08
`define UAT_TRIG_1        7'h10
`define UAT_TRIG_2        7'h20
`define UAT_TRIG_3        7'h38
`define UAT_TMO_CHARS     2
`define UAT_TMO_EXTRA     7'h0C
`define UAT_FLOW_SCALE    2

`endif

// file: hw/uat_pkg.sv
// types shared by the uart datapath files
package uat_pkg;

	// axi4-lite master to slave
	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} uat_axi_req_t;

	// axi4-lite slave to master
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} uat_axi_rsp_t;

	typedef enum logic [2:0] {
		TX_IDLE  = 3'b000,
		TX_START = 3'b001,
		TX_DATA  = 3'b010,
		TX_PAR   = 3'b011,
		TX_STOP  = 3'b100
	} uat_tx_st_t;

	typedef enum logic [2:0] {
		RX_IDLE  = 3'b000,
		RX_START = 3'b001,
		RX_DATA  = 3'b010,
		RX_PAR   = 3'b011,
		RX_STOP  = 3'b100
	} uat_rx_st_t;

	// whole state of the core
	typedef struct packed {
		logic        aw_hold;
		logic [7:0]  aw_addr;
		logic        w_hold;
		logic [7:0]  w_data;
		logic        w_lane0;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [7:0]  rdata;
		logic [1:0]  rresp;
		logic [7:0]  ien;
		logic [7:0]  lctl;
		logic [7:0]  mctl;
		logic [7:0]  efeat;
		logic [7:0]  fthr;
		logic [7:0]  dfrac;
		logic        fifo_en;
		logic [1:0]  rx_trig;
		logic [1:0]  tx_trig;
		logic [5:0]  tx_wr;
		logic [5:0]  tx_rd;
		logic [6:0]  tx_cnt;
		logic [5:0]  rx_wr;
		logic [5:0]  rx_rd;
		logic [6:0]  rx_cnt;
		uat_tx_st_t  tx_st;
		logic [4:0]  tx_os;
		logic [2:0]  tx_bit;
		logic [7:0]  tx_shifter;
		logic        tx_par;
		logic        txd;
		uat_rx_st_t  rx_st;
		logic [4:0]  rx_os;
		logic [2:0]  rx_bit;
		logic [7:0]  rx_shifter;
		logic        rx_pbit;
		logic        rx_perr;
		logic        rxd_prev;
		logic        cts_prev;
		logic [4:0]  bt_os;
		logic [6:0]  tmo;
		logic        rx_tmo;
		logic        overrun;
		logic        flow_evt;
		logic        halt;
		logic        rts_n;
	} uat_state_t;

endpackage : uat_pkg

// file: hw/uat_mem.sv
// 64-entry fifo storage with registered read data
`timescale 1ns/100ps
`include "uat_defines.svh"

module uat_mem #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             core_clk, // core clock
	input  wire logic             we,       // write strobe
	input  wire logic [5:0]       waddr,    // write address
	input  wire logic [WIDTH-1:0] wdata,    // write data
	input  wire logic [5:0]       raddr,    // read address for next cycle
	output logic      [WIDTH-1:0] rdata     // registered read data
);
	import uat_pkg::*;

	logic [WIDTH-1:0] mem_q [0:`UAT_FIFO_DEPTH-1];
	logic [WIDTH-1:0] rdata_q;

	// storage array has no reset; contents are read behind a nonzero count, except that a holding read returns the head even when empty
	always_ff @(posedge core_clk) begin
		if (we) begin
			mem_q[waddr] <= wdata;
		end
	end

	// bypass keeps the head fresh when a write lands on the address being read
	always_ff @(posedge core_clk) begin
		if (we && (waddr == raddr)) begin
			rdata_q <= wdata;
		end else begin
			rdata_q <= mem_q[raddr];
		end
	end

	assign rdata = rdata_q;

endmodule : uat_mem

// file: bench/uat_core_assertions.sv
// port checker for the uart core
`timescale 1ns/100ps
module uat_chk (
	input wire logic                  core_clk, // clock
	input wire logic                  rst_n,    // reset, active low
	input wire uat_pkg::uat_axi_req_t axi_req,  // bus requests
	input wire uat_pkg::uat_axi_rsp_t axi_rsp,  // bus answers
	input wire logic                  txd       // serial out
);
	import uat_pkg::*;
	logic       txd_q; // txd a cycle back
	logic [7:0] run_q; // cycles a level has held
	// saturates so a long idle never wraps into a short run
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			txd_q <= 1'b1;
			run_q <= 8'h00;
		end else begin
			txd_q <= txd;
			if (txd != txd_q) run_q <= 8'h00;
			else if (run_q != 8'hff) run_q <= run_q + 8'h01;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence aw_w_taken;
		axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
	endsequence
	ar_free_a: assert property (axi_rsp.arready == !axi_rsp.rvalid) else $error("arready wrong");
	w_block_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready) else $error("no block");
	b_time_a: assert property (aw_w_taken |-> ##[1:2] axi_rsp.bvalid) else $error("late bvalid");
	r_time_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid) else $error("late rvalid");
	b_done_a: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid) else $error("bvalid stuck");
	r_done_a: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid) else $error("rvalid stuck");
	r_upper_a: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == '0) else $error("rdata high");
	bit_len_a: assert property (txd != txd_q |-> run_q >= 8'h05) else $error("bit too short");
endmodule : uat_chk
bind uat_core uat_chk uat_chk_inst (.core_clk(core_clk), .rst_n(rst_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
	.txd(txd));

// file: bench/uat_remote.sv
// remote uart: oversampling ticks and both serial directions
`timescale 1ns/100ps
module uat_remote (
	input  wire logic core_clk, // clock
	input  wire logic txd,      // from the core
	output logic      os_tick,  // tick every other cycle
	output logic      rxd       // to the core, idles high
);
	int cpb = 32; // cycles per bit, two per tick
	initial os_tick = 1'b0;
	initial rxd = 1'b1;
	// free-running tick stands in for the baud generator
	always @(posedge core_clk) os_tick <= !os_tick;
	// frame bits go out f[0] first
	task send(input logic [9:0] f);
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (cpb) @(posedge core_clk);
		end
	endtask : send
	// samples at bit centres, stop bit lands in b[8]
	task recv(output logic [8:0] b);
		@(negedge txd);
		repeat (cpb / 2) @(posedge core_clk);
		for (int i = 0; i < 9; i++) begin
			repeat (cpb) @(posedge core_clk);
			b[i] = txd;
		end
	endtask : recv
endmodule : uat_remote

// file: bench/testbench.sv
// self-checking bench for the uart core
`timescale 1ns/100ps
`include "uat_defines.svh"
module testbench;
	import uat_pkg::*;
	logic         core_clk, rst_n, cts_n, os_tick, rxd, txd, rts_n;
	uat_axi_req_t req;
	uat_axi_rsp_t rsp, s;
	logic [31:0]  rv;
	logic [1:0]   br;
	logic [8:0]   got;
	int           miscompares = 0;
	int           check_count = 0;
	int           cyc = 0;
	uat_core uat_core_inst (.core_clk(core_clk), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp),
		.os_tick(os_tick), .rxd(rxd), .txd(txd), .cts_n(cts_n), .rts_n(rts_n));
	uat_remote uat_remote_inst (.core_clk(core_clk), .txd(txd), .os_tick(os_tick), .rxd(rxd));
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = !core_clk;
	end
	// a hang counts as a mismatch
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 40000) begin
			miscompares++;
			give_verdict();
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task give_verdict();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	// one write or read; answers are judged on values settled before the edge
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		req <= '{awvalid: w, awaddr: a, wvalid: w, wdata: 32'(d), wstrb: 4'hf, bready: w,
			arvalid: !w, araddr: a, rready: !w};
		do begin
			@(negedge core_clk);
			s = rsp;
			@(posedge core_clk);
			if (s.awready) req.awvalid <= 1'b0;
			if (s.wready) req.wvalid <= 1'b0;
			if (s.arready) req.arvalid <= 1'b0;
		end while (!s.bvalid && !s.rvalid);
		{req.bready, req.rready} <= 2'b00;
		rv = s.rdata;
		br = w ? s.bresp : s.rresp;
	endtask : bus
	task rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 8'h00);
		chk(rv, e);
	endtask : rc
	// reset state, refusals, one byte per sampling mode
	task t_tx();
		rc(`UAT_OFS_LSTAT, 8'h60);
		rc(`UAT_OFS_ISTAT, 8'h01);
		bus(1'b1, `UAT_OFS_LSTAT, 8'h00);
		chk(br, `UAT_RESP_SLVERR);
		bus(1'b0, 8'h24, 8'h00);
		chk(br, `UAT_RESP_SLVERR);
		bus(1'b1, `UAT_OFS_LCTL, 8'h03);
		bus(1'b1, `UAT_OFS_ISTAT, 8'h01);
		for (int m = 0; m < 3; m++) begin
			bus(1'b1, `UAT_OFS_DFRAC, 8'(m << 4));
			uat_remote_inst.cpb = 32 >> m;
			fork
				begin
					bus(1'b1, `UAT_OFS_HOLD, 8'ha5 ^ 8'(m));
					rc(`UAT_OFS_LSTAT, 8'h20);
				end
				uat_remote_inst.recv(got);
			join
			chk(got, 9'h1a5 ^ m);
			// let the stop bit finish before the mode changes again
			repeat (32) @(posedge core_clk);
			rc(`UAT_OFS_LSTAT, 8'h60);
		end
		bus(1'b1, `UAT_OFS_IEN, 8'h02);
		rc(`UAT_OFS_ISTAT, 8'hc2);
	endtask : t_tx
	// false start, then a byte left waiting until the timeout shows
	task t_rx();
		bus(1'b1, `UAT_OFS_DFRAC, 8'h00);
		bus(1'b1, `UAT_OFS_IEN, 8'h01);
		uat_remote_inst.cpb = 6;
		uat_remote_inst.send(10'h3fe);
		rc(`UAT_OFS_LSTAT, 8'h60);
		uat_remote_inst.cpb = 32;
		uat_remote_inst.send({1'b1, 8'h3c, 1'b0});
		rc(`UAT_OFS_ISTAT, 8'hc1);
		repeat (1580) @(posedge core_clk);
		rc(`UAT_OFS_ISTAT, 8'hc1);
		repeat (100) @(posedge core_clk);
		rc(`UAT_OFS_ISTAT, 8'hcc);
		rc(`UAT_OFS_LSTAT, 8'h61);
		rc(`UAT_OFS_HOLD, 8'h3c);
		rc(`UAT_OFS_ISTAT, 8'hc1);
	endtask : t_rx
	// halt at four entries, keep storing, resume once drained
	task t_rts();
		bus(1'b1, `UAT_OFS_EFEAT, 8'h50);
		bus(1'b1, `UAT_OFS_IEN, 8'h40);
		bus(1'b1, `UAT_OFS_FTHR, 8'h01);
		bus(1'b1, `UAT_OFS_MCTL, 8'h02);
		repeat (3) @(negedge core_clk);
		chk(rts_n, 1'b0);
		for (int i = 0; i < 5; i++) begin
			uat_remote_inst.send({1'b1, 8'(8'h10 + i), 1'b0});
			chk(rts_n, i > 2);
		end
		rc(`UAT_OFS_ISTAT, 8'he0);
		for (int i = 0; i < 5; i++) rc(`UAT_OFS_HOLD, 8'h10 + i);
		repeat (3) @(negedge core_clk);
		chk(rts_n, 1'b0);
	endtask : t_rts
	// a byte held back while clear-to-send is high
	task t_cts();
		bus(1'b1, `UAT_OFS_EFEAT, 8'h90);
		bus(1'b1, `UAT_OFS_IEN, 8'h80);
		cts_n <= 1'b1;
		fork
			begin
				bus(1'b1, `UAT_OFS_HOLD, 8'h5a);
				rc(`UAT_OFS_ISTAT, 8'he0);
				repeat (200) @(posedge core_clk);
				chk(txd, 1'b1);
				cts_n <= 1'b0;
			end
			uat_remote_inst.recv(got);
		join
		chk(got, 9'h15a);
	endtask : t_cts
	// seven data bits with even parity both ways; a bad parity bit gets tagged
	task t_par();
		repeat (32) @(posedge core_clk);
		bus(1'b1, `UAT_OFS_LCTL, 8'h1a);
		fork
			bus(1'b1, `UAT_OFS_HOLD, 8'h87);
			uat_remote_inst.recv(got);
		join
		chk(got, 9'h187);
		uat_remote_inst.send({1'b1, 1'b0, 7'h07, 1'b0});
		rc(`UAT_OFS_LSTAT, 8'h65);
		rc(`UAT_OFS_HOLD, 8'h07);
	endtask : t_par
	initial begin
		rst_n = 1'b0;
		cts_n = 1'b0;
		req = '0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		t_tx();
		t_rx();
		t_rts();
		t_cts();
		t_par();
		give_verdict();
	end
endmodule : testbench
